/* dpwm_top.v */
// Purpose: Two PWM generators with dead-band, event selectors, sync and output control.
// Assumes: One clock, synchronous active-high reset, APB register access.
// Notes: Event bit order everywhere is zero, load, A up, A down, B up, B down.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dpwm_consts.vh"
module dpwm_top #(
  parameter CW = 16
) (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire fault_in,
  input wire dbg_stall,
  output reg [3:0] pwm_out,
  output wire irq,
  output reg [1:0] adc_trig
);
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  reg [1:0] gsync_q;
  reg [3:0] enable_q;
  reg [3:0] invert_q;
  reg [3:0] fault_q;
  reg [2:0] inten_q;
  reg fault_ris_q;
  reg [5:0] gctl_q [0:1];
  reg [13:0] ginten_q [0:1];
  reg [5:0] gris_q [0:1];
  reg [CW-1:0] load_sh_q [0:1];
  reg [CW-1:0] cmpa_sh_q [0:1];
  reg [CW-1:0] cmpb_sh_q [0:1];
  reg [CW-1:0] load_q [0:1];
  reg [CW-1:0] cmpa_q [0:1];
  reg [CW-1:0] cmpb_q [0:1];
  reg [11:0] gena_q [0:1];
  reg [11:0] genb_q [0:1];
  reg dben_q [0:1];
  reg [11:0] dbrise_q [0:1];
  reg [11:0] dbfall_q [0:1];
  reg [CW-1:0] cnt_q [0:1];
  reg dir_q [0:1];
  reg pend_q [0:1];
  reg pwa_q [0:1];
  reg pwb_q [0:1];
  reg [11:0] dbc_q [0:1];
  reg dba_q [0:1];
  reg dbb_q [0:1];
  reg pin_prev_q [0:1];
  reg zero_seen_q [0:1];
  reg [1:0] sync_rst;
  reg [5:0] ev [0:1];
  reg [3:0] gen_out;
  reg [1:0] live;
  reg [1:0] hit_a;
  reg [1:0] hit_b;
  reg [11:0] db_age [0:1];
  wire gsel = paddr[7];
  wire gacc = (paddr[11:6] == 6'h01) | (paddr[11:6] == 6'h02);
  wire [5:0] goff = paddr[5:0];
  integer g;
  integer gi;
  integer gm;

  // Event decode from the counter state, raw and undelayed.
  always @* begin
    for (gi = 0; gi < 2; gi = gi + 1) begin
      live[gi] = gctl_q[gi][`DPWM_CTL_EN] & ~(dbg_stall & ~gctl_q[gi][`DPWM_CTL_DBG_RUN] & zero_seen_q[gi]);
      hit_a[gi] = (cnt_q[gi] == cmpa_q[gi]) & (cmpa_q[gi] <= load_q[gi]);
      hit_b[gi] = (cnt_q[gi] == cmpb_q[gi]) & (cmpb_q[gi] <= load_q[gi]);
      ev[gi][0] = live[gi] & (cnt_q[gi] == {CW{1'b0}});
      ev[gi][1] = live[gi] & (cnt_q[gi] == load_q[gi]);
      ev[gi][2] = live[gi] & hit_a[gi] & dir_q[gi];
      ev[gi][3] = live[gi] & hit_a[gi] & ~dir_q[gi];
      ev[gi][4] = live[gi] & hit_b[gi] & dir_q[gi];
      ev[gi][5] = live[gi] & hit_b[gi] & ~dir_q[gi];
      // Cycles the first generated output has held its present level.
      db_age[gi] = (pwa_q[gi] != pin_prev_q[gi]) ? 12'h000 : dbc_q[gi];
    end
  end

  function act;
    input cur;
    input [1:0] a;
    begin
      case (a)
        `DPWM_ACTION_TOG: act = ~cur;
        `DPWM_ACTION_LOW: act = 1'b0;
        `DPWM_ACTION_HIGH: act = 1'b1;
        default: act = cur;
      endcase
    end
  endfunction

  function apply;
    input cur;
    input [11:0] gen;
    input [5:0] e;
    input own_b;
    reg v;
    reg m_ok;
    begin
      v = cur;
      m_ok = ~(e[0] | e[1]);
      if (e[0]) v = act(v, gen[`DPWM_ACT_ZERO+:2]);
      if (e[1]) v = act(v, gen[`DPWM_ACT_LOAD+:2]);
      // A for first, B for second
      if (m_ok & ~own_b & e[2]) v = act(v, gen[`DPWM_ACT_AUP+:2]);
      if (m_ok & ~own_b & e[3]) v = act(v, gen[`DPWM_ACT_ADN+:2]);
      if (m_ok & own_b & e[4]) v = act(v, gen[`DPWM_ACT_BUP+:2]);
      if (m_ok & own_b & e[5]) v = act(v, gen[`DPWM_ACT_BDN+:2]);
      apply = v;
    end
  endfunction

  always @(posedge sys_clk) begin
    if (srst) begin
      gsync_q <= 2'h0;
      enable_q <= 4'h0;
      invert_q <= 4'h0;
      fault_q <= 4'h0;
      inten_q <= 3'h0;
      fault_ris_q <= 1'b0;
      sync_rst <= 2'h0;
      adc_trig <= 2'h0;
      for (g = 0; g < 2; g = g + 1) begin
        gctl_q[g] <= 6'h00;
        ginten_q[g] <= 14'h0000;
        gris_q[g] <= 6'h00;
        load_sh_q[g] <= {CW{1'b0}};
        cmpa_sh_q[g] <= {CW{1'b0}};
        cmpb_sh_q[g] <= {CW{1'b0}};
        load_q[g] <= {CW{1'b0}};
        cmpa_q[g] <= {CW{1'b0}};
        cmpb_q[g] <= {CW{1'b0}};
        gena_q[g] <= 12'h000;
        genb_q[g] <= 12'h000;
        dben_q[g] <= 1'b0;
        dbrise_q[g] <= 12'h000;
        dbfall_q[g] <= 12'h000;
        cnt_q[g] <= {CW{1'b0}};
        dir_q[g] <= 1'b0;
        pend_q[g] <= 1'b0;
        pwa_q[g] <= 1'b0;
        pwb_q[g] <= 1'b0;
        dbc_q[g] <= 12'h000;
        dba_q[g] <= 1'b0;
        dbb_q[g] <= 1'b0;
        pin_prev_q[g] <= 1'b0;
        zero_seen_q[g] <= 1'b0;
      end
    end else begin
      sync_rst <= 2'h0;
      if (wr_en & (paddr == `DPWM_OFS_ISC) & pwdata[`DPWM_ISC_FAULT])
        fault_ris_q <= fault_in;
      else if (fault_in)
        fault_ris_q <= 1'b1;
      for (g = 0; g < 2; g = g + 1) begin
        // Counter with stall handling.
        if (sync_rst[g] | ~gctl_q[g][`DPWM_CTL_EN]) begin
          cnt_q[g] <= {CW{1'b0}};
          dir_q[g] <= 1'b0;
          zero_seen_q[g] <= 1'b0;
        end else if (dbg_stall & ~gctl_q[g][`DPWM_CTL_DBG_RUN] & (zero_seen_q[g] | ev[g][0])) begin
          zero_seen_q[g] <= 1'b1;
        end else if (gctl_q[g][`DPWM_CTL_UPDN]) begin
          zero_seen_q[g] <= 1'b0;
          if (ev[g][1] | (cnt_q[g] > load_q[g])) begin
            dir_q[g] <= 1'b0;
            cnt_q[g] <= (cnt_q[g] == {CW{1'b0}}) ? {CW{1'b0}} : cnt_q[g] - 1'b1;
          end else if (ev[g][0]) begin
            dir_q[g] <= 1'b1;
            cnt_q[g] <= cnt_q[g] + 1'b1;
          end else if (dir_q[g])
            cnt_q[g] <= cnt_q[g] + 1'b1;
          else
            cnt_q[g] <= cnt_q[g] - 1'b1;
        end else begin
          zero_seen_q[g] <= 1'b0;
          dir_q[g] <= 1'b0;
          if (ev[g][0] | (cnt_q[g] > load_q[g]))
            cnt_q[g] <= load_q[g];
          else
            cnt_q[g] <= cnt_q[g] - 1'b1;
        end
        if (ev[g][0] & (~gctl_q[g][`DPWM_CTL_LOAD_SYNC] | pend_q[g])) load_q[g] <= load_sh_q[g];
        if (ev[g][0] & (~gctl_q[g][`DPWM_CTL_CMPA_SYNC] | pend_q[g])) cmpa_q[g] <= cmpa_sh_q[g];
        if (ev[g][0] & (~gctl_q[g][`DPWM_CTL_CMPB_SYNC] | pend_q[g])) cmpb_q[g] <= cmpb_sh_q[g];
        // A request that arrives on a zero waits for the following zero.
        if (ev[g][0])
          pend_q[g] <= 1'b0;
        else if (gsync_q[g])
          pend_q[g] <= 1'b1;
        if (~gctl_q[g][`DPWM_CTL_EN]) begin
          load_q[g] <= load_sh_q[g];
          cmpa_q[g] <= cmpa_sh_q[g];
          cmpb_q[g] <= cmpb_sh_q[g];
        end
        pwa_q[g] <= apply(pwa_q[g], gena_q[g], ev[g], 1'b0);
        pwb_q[g] <= apply(pwb_q[g], genb_q[g], ev[g], 1'b1);
        pin_prev_q[g] <= pwa_q[g];
        if (pwa_q[g] != pin_prev_q[g])
          dbc_q[g] <= 12'h001;
        else if (dbc_q[g] != 12'hfff)
          dbc_q[g] <= dbc_q[g] + 1'b1;
        // Each output rises only once the level is old enough; falling edges pass at once.
        dba_q[g] <= pwa_q[g] & (db_age[g] >= dbrise_q[g]);
        dbb_q[g] <= ~pwa_q[g] & (db_age[g] >= dbfall_q[g]);
        if (wr_en & gacc & (gsel == g[0]) & (goff == `DPWM_G_ISC))
          gris_q[g] <= (gris_q[g] & ~pwdata[5:0]) | (ev[g] & ginten_q[g][5:0]);
        else
          gris_q[g] <= gris_q[g] | (ev[g] & ginten_q[g][5:0]);
        adc_trig[g] <= |(ev[g] & ginten_q[g][`DPWM_TRIG_POS+:6]);
      end
      if (ev[0][0] & pend_q[0]) gsync_q[0] <= 1'b0;
      if (ev[1][0] & pend_q[1]) gsync_q[1] <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `DPWM_OFS_CTL: gsync_q <= gsync_q | pwdata[1:0];
          `DPWM_OFS_SYNC: sync_rst <= pwdata[1:0];
          `DPWM_OFS_ENABLE: enable_q <= pwdata[3:0];
          `DPWM_OFS_INVERT: invert_q <= pwdata[3:0];
          `DPWM_OFS_FAULT: fault_q <= pwdata[3:0];
          `DPWM_OFS_INTEN: inten_q <= {pwdata[16], pwdata[1:0]};
          default: ;
        endcase
        if (gacc) begin
          case (goff)
            `DPWM_G_CTL: gctl_q[gsel] <= pwdata[5:0];
            `DPWM_G_INTEN: ginten_q[gsel] <= {pwdata[13:8], 2'h0, pwdata[5:0]};
            `DPWM_G_LOAD: load_sh_q[gsel] <= pwdata[CW-1:0];
            `DPWM_G_CMPA: cmpa_sh_q[gsel] <= pwdata[CW-1:0];
            `DPWM_G_CMPB: cmpb_sh_q[gsel] <= pwdata[CW-1:0];
            `DPWM_G_GENA: gena_q[gsel] <= pwdata[11:0];
            `DPWM_G_GENB: genb_q[gsel] <= pwdata[11:0];
            `DPWM_G_DBCTL: dben_q[gsel] <= pwdata[0];
            `DPWM_G_DBRISE: dbrise_q[gsel] <= pwdata[11:0];
            `DPWM_G_DBFALL: dbfall_q[gsel] <= pwdata[11:0];
            default: ;
          endcase
        end
      end
    end
  end

  wire [1:0] gen_irq = {|(gris_q[1] & ginten_q[1][5:0]), |(gris_q[0] & ginten_q[0][5:0])};
  wire [2:0] ris = {fault_ris_q, |gris_q[1], |gris_q[0]};
  assign irq = |({fault_ris_q, gen_irq} & inten_q);
  assign pslverr = 1'b0;

  always @* begin
    for (gm = 0; gm < 2; gm = gm + 1) begin
      gen_out[2*gm] = dben_q[gm] ? dba_q[gm] : pwa_q[gm];
      gen_out[2*gm+1] = dben_q[gm] ? dbb_q[gm] : pwb_q[gm];
    end
  end

  always @(posedge sys_clk) begin
    if (srst)
      pwm_out <= 4'h0;
    else
      pwm_out <= (gen_out & enable_q & ~({4{fault_in}} & fault_q)) ^ invert_q;
  end

  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `DPWM_OFS_CTL: prdata = {30'h0, gsync_q};
        `DPWM_OFS_ENABLE: prdata = {28'h0, enable_q};
        `DPWM_OFS_INVERT: prdata = {28'h0, invert_q};
        `DPWM_OFS_FAULT: prdata = {28'h0, fault_q};
        `DPWM_OFS_INTEN: prdata = {15'h0, inten_q[2], 14'h0, inten_q[1:0]};
        `DPWM_OFS_RIS: prdata = {15'h0, ris[2], 14'h0, ris[1:0]};
        `DPWM_OFS_ISC: prdata = {15'h0, ris[2] & inten_q[2], 14'h0, gen_irq & inten_q[1:0]};
        `DPWM_OFS_STATUS: prdata = {31'h0, fault_in};
        default: ;
      endcase
      if (gacc) begin
        case (goff)
          `DPWM_G_CTL: prdata = {26'h0, gctl_q[gsel]};
          `DPWM_G_INTEN: prdata = {18'h0, ginten_q[gsel][13:8], 2'h0, ginten_q[gsel][5:0]};
          `DPWM_G_RIS: prdata = {26'h0, gris_q[gsel]};
          `DPWM_G_ISC: prdata = {26'h0, gris_q[gsel] & ginten_q[gsel][5:0]};
          `DPWM_G_LOAD: prdata = {{(32-CW){1'b0}}, load_sh_q[gsel]};
          `DPWM_G_COUNT: prdata = {{(32-CW){1'b0}}, cnt_q[gsel]};
          `DPWM_G_CMPA: prdata = {{(32-CW){1'b0}}, cmpa_sh_q[gsel]};
          `DPWM_G_CMPB: prdata = {{(32-CW){1'b0}}, cmpb_sh_q[gsel]};
          `DPWM_G_GENA: prdata = {20'h0, gena_q[gsel]};
          `DPWM_G_GENB: prdata = {20'h0, genb_q[gsel]};
          `DPWM_G_DBCTL: prdata = {31'h0, dben_q[gsel]};
          `DPWM_G_DBRISE: prdata = {20'h0, dbrise_q[gsel]};
          `DPWM_G_DBFALL: prdata = {20'h0, dbfall_q[gsel]};
          default: ;
        endcase
      end
    end
  end
endmodule // dpwm_top

/* dpwm_consts.vh */
// Purpose: Register offsets, field positions and reset values for the dual generator PWM block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Generator registers repeat with a stride of 0x40.
`ifndef DPWM_CONSTS_VH
`define DPWM_CONSTS_VH
`define DPWM_OFS_CTL 12'h000
`define DPWM_OFS_SYNC 12'h004
`define DPWM_OFS_ENABLE 12'h008
`define DPWM_OFS_INVERT 12'h00c
`define DPWM_OFS_FAULT 12'h010
`define DPWM_OFS_INTEN 12'h014
`define DPWM_OFS_RIS 12'h018
`define DPWM_OFS_ISC 12'h01c
`define DPWM_OFS_STATUS 12'h020
`define DPWM_GEN_BASE0 12'h040
`define DPWM_GEN_BASE1 12'h080
`define DPWM_G_CTL 6'h00
`define DPWM_G_INTEN 6'h04
`define DPWM_G_RIS 6'h08
`define DPWM_G_ISC 6'h0c
`define DPWM_G_LOAD 6'h10
`define DPWM_G_COUNT 6'h14
`define DPWM_G_CMPA 6'h18
`define DPWM_G_CMPB 6'h1c
`define DPWM_G_GENA 6'h20
`define DPWM_G_GENB 6'h24
`define DPWM_G_DBCTL 6'h28
`define DPWM_G_DBRISE 6'h2c
`define DPWM_G_DBFALL 6'h30
// Generator control fields.
`define DPWM_CTL_EN 0
`define DPWM_CTL_UPDN 1
`define DPWM_CTL_DBG_RUN 2
`define DPWM_CTL_LOAD_SYNC 3
`define DPWM_CTL_CMPA_SYNC 4
`define DPWM_CTL_CMPB_SYNC 5
// Action field positions in the generator action registers.
`define DPWM_ACT_ZERO 0
`define DPWM_ACT_LOAD 2
`define DPWM_ACT_AUP 4
`define DPWM_ACT_ADN 6
`define DPWM_ACT_BUP 8
`define DPWM_ACT_BDN 10
`define DPWM_ACTION_NONE 2'h0
`define DPWM_ACTION_TOG 2'h1
`define DPWM_ACTION_LOW 2'h2
`define DPWM_ACTION_HIGH 2'h3
// Event selector: interrupt in bits 5:0, ADC trigger in bits 13:8.
`define DPWM_TRIG_POS 8
`define DPWM_ISC_FAULT 16
`define DPWM_RESET_VAL 32'h00000000
`endif

/* dpwm_sva.sv */
// Purpose: Port checker for the dual generator PWM block.
// Assumes: Shadow copies of a few global registers are rebuilt from APB writes.
// Notes: Output checks only stand where the inversion setting is known.
`timescale 1ns/1ps
`include "dpwm_consts.vh"
module dpwm_sva #(parameter CW = 16) (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fault_in,
  input wire dbg_stall,
  input wire [3:0] pwm_out,
  input wire irq,
  input wire [1:0] adc_trig
);
  reg [3:0] en_q, inv_q, flt_q;
  reg [31:0] ien_q;
  wire wr = psel && penable && pwrite;
  always @(posedge sys_clk) begin
    if (srst) begin
      en_q <= 4'h0;
      inv_q <= 4'h0;
      flt_q <= 4'h0;
      ien_q <= 32'h0;
    end else if (wr) begin
      if (paddr == `DPWM_OFS_ENABLE) en_q <= pwdata[3:0];
      if (paddr == `DPWM_OFS_INVERT) inv_q <= pwdata[3:0];
      if (paddr == `DPWM_OFS_FAULT) flt_q <= pwdata[3:0];
      if (paddr == `DPWM_OFS_INTEN) ien_q <= pwdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ready_tied_a: assert property (pready) else $error("pready low");
  no_error_a: assert property (!pslverr) else $error("pslverr high");
  read_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata outside access");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 12'hffc |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> pwm_out == 4'h0 && adc_trig == 2'h0 && !irq)
    else $error("outputs active after reset");
  gate_off_a: assert property ((en_q == 4'h0 && inv_q == 4'h0) [*3] |-> pwm_out == 4'h0)
    else $error("disabled output drives pin");
  invert_all_a: assert property ((en_q == 4'h0 && inv_q == 4'hf) [*3] |-> pwm_out == 4'hf)
    else $error("inverted idle pin not high");
  fault_off_a: assert property ((fault_in && flt_q == 4'hf && inv_q == 4'h0) [*4] |-> pwm_out == 4'h0)
    else $error("fault did not force outputs low");
  irq_masked_a: assert property ((ien_q == 32'h0) [*2] |-> !irq)
    else $error("masked interrupt visible");
  cover property (adc_trig[0]);
  cover property ($rose(irq));
  cover property (fault_in && flt_q != 4'h0);
endmodule // dpwm_sva
bind dpwm_top dpwm_sva #(.CW(CW)) dpwm_sva_i (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .fault_in, .dbg_stall, .pwm_out, .irq, .adc_trig);

/* dpwm_pwr_stage.sv */
// Purpose: Behavioural half-bridge stage fed by the first output pair.
// Assumes: Both switches conduct while their gate is high.
// Notes: Counts cycles in which both switches would conduct at once.
`timescale 1ns/1ps
module dpwm_pwr_stage (
  input wire sys_clk,
  input wire srst,
  input wire logic [3:0] gate,
  output int shoot
);
  always @(posedge sys_clk) begin
    if (srst) shoot <= 0;
    else if (gate[0] === 1'b1 && gate[1] === 1'b1) shoot <= shoot + 1;
  end
endmodule // dpwm_pwr_stage

/* dual_pwm_generator_deadband_bench.sv */
// Purpose: Self-checking bench for the dual generator PWM block.
// Assumes: Zero-wait APB slave, PWM outputs two register stages behind events (three with dead-band on), ADC triggers one.
// Notes: Widths and periods are measured on the pins in clock cycles.
`timescale 1ns/1ps
`include "dpwm_consts.vh"
module dual_pwm_generator_deadband_bench;
  logic sys_clk, srst, psel, penable, pwrite, fault_in, dbg_stall, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pwm_out;
  logic [1:0] adc_trig;
  wire logic [5:0] sig = {adc_trig, pwm_out};
  int n_fail = 0, cmp_count = 0, cyc = 0, shoot, s0, hi, per;
  localparam logic [11:0] G0 = `DPWM_GEN_BASE0, G1 = `DPWM_GEN_BASE1;
  dpwm_top #(.CW(16)) dpwm_top_i (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_in, .dbg_stall, .pwm_out, .irq, .adc_trig);
  dpwm_pwr_stage dpwm_pwr_stage_i (.sys_clk(sys_clk), .srst(srst), .gate(pwm_out), .shoot(shoot));
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      finish_test;
    end
  end
  task chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task gcfg(input logic [11:0] b, input logic [31:0] c, l, ca, ga);
    wr(b + `DPWM_G_CTL, 0); wr(b + `DPWM_G_LOAD, l); wr(b + `DPWM_G_CMPA, ca);
    wr(b + `DPWM_G_GENA, ga); wr(b + `DPWM_G_CTL, c);
  endtask
  task meas(input int b);
    hi = 0;
    for (int k = 0; k < 300 && sig[b] !== 1'b0; k++) @(posedge sys_clk);
    for (int k = 0; k < 300 && sig[b] !== 1'b1; k++) @(posedge sys_clk);
    while (sig[b] === 1'b1 && hi < 300) begin hi++; @(posedge sys_clk); end
    per = hi;
    while (sig[b] !== 1'b1 && per < 300) begin per++; @(posedge sys_clk); end
  endtask
  task t_regs;
    apb(0, `DPWM_OFS_ENABLE, 0); chk(rd, `DPWM_RESET_VAL);
    wr(G0 + `DPWM_G_LOAD, 32'h1234); apb(0, G0 + `DPWM_G_LOAD, 0); chk(rd, 32'h1234);
    wr(12'hffc, 32'h5); apb(0, 12'hffc, 0); chk(rd, 32'h0);
  endtask
  task t_down;
    wr(`DPWM_OFS_ENABLE, 32'hf);
    gcfg(G0, 1, 9, 6, 32'h83); meas(0);
    chk(per, 10);
    chk(hi, 4);
    gcfg(G0, 1, 9, 6, 32'h1); meas(0);
    chk(hi, 10);
    gcfg(G0, 1, 9, 6, 32'h83); wr(G0 + `DPWM_G_LOAD, 4); wr(G0 + `DPWM_G_CMPA, 2); meas(0); meas(0);
    chk(per, 5);
    chk(hi, 3);
  endtask
  task t_gsync;
    gcfg(G0, 32'h9, 9, 6, 32'h83); wr(G0 + `DPWM_G_LOAD, 4); wr(G0 + `DPWM_G_CMPA, 2); meas(0); meas(0);
    chk(per, 10);
    chk(hi, 8);
    wr(`DPWM_OFS_CTL, 1); meas(0); meas(0);
    chk(per, 5);
    apb(0, `DPWM_OFS_CTL, 0); chk(rd, 0);
  endtask
  task t_updn;
    wr(G0 + `DPWM_G_CMPB, 5); gcfg(G0, 3, 8, 5, 32'heb0); meas(0);
    chk(per, 16);
    chk(hi, 6);
  endtask
  task t_edge;
    for (int i = 0; i < 2; i++) begin
      gcfg(G0, 1, 9, i ? 0 : 10, i ? 32'h43 : 32'h83);
      repeat (12) @(posedge sys_clk);
      for (int k = 0; k < 12; k++) begin @(posedge sys_clk); chk(pwm_out[0], 1); end
    end
  endtask
  task t_trig;
    gcfg(G0, 1, 9, 6, 32'h83); wr(G0 + `DPWM_G_INTEN, 32'h101); wr(`DPWM_OFS_INTEN, 1);
    repeat (12) @(posedge sys_clk); chk(irq, 1);
    wr(`DPWM_OFS_INTEN, 0); @(posedge sys_clk); chk(irq, 0);
    wr(`DPWM_OFS_INTEN, 1);
    for (int e = 1; e < 4; e++) begin
      wr(G0 + `DPWM_G_INTEN, e << 8); wr(G0 + `DPWM_G_ISC, 32'h3f); @(posedge sys_clk);
      chk(irq, 0);
      meas(4);
      chk(hi, e == 3 ? 2 : 1);
      chk(per, 10);
    end
  endtask
  task t_sync;
    gcfg(G0, 1, 9, 6, 32'h83); gcfg(G1, 1, 9, 6, 32'h83); wr(`DPWM_OFS_SYNC, 3);
    repeat (4) @(posedge sys_clk);
    for (int k = 0; k < 20; k++) begin @(posedge sys_clk); chk(pwm_out[2], pwm_out[0]); end
  endtask
  task t_stall;
    gcfg(G0, 1, 9, 6, 32'h83); dbg_stall <= 1; repeat (30) @(posedge sys_clk);
    apb(0, G0 + `DPWM_G_COUNT, 0); chk(rd, 0);
    wr(G0 + `DPWM_G_INTEN, 1); wr(G0 + `DPWM_G_ISC, 32'h3f);
    repeat (7) @(posedge sys_clk); apb(0, G0 + `DPWM_G_COUNT, 0); chk(rd, 0);
    apb(0, G0 + `DPWM_G_RIS, 0); chk(rd, 0);
    dbg_stall <= 0; wr(G0 + `DPWM_G_INTEN, 0);
  endtask
  task t_db;
    gcfg(G0, 1, 19, 10, 32'h83); wr(G0 + `DPWM_G_DBRISE, 3); wr(G0 + `DPWM_G_DBFALL, 2);
    wr(G0 + `DPWM_G_DBCTL, 1); meas(0); s0 = shoot; meas(0);
    chk(hi, 7);
    chk(per, 20);
    meas(1);
    chk(hi, 8);
    chk(shoot - s0, 0);
    wr(G0 + `DPWM_G_DBCTL, 0);
  endtask
  task t_fault;
    wr(`DPWM_OFS_ENABLE, 0); wr(`DPWM_OFS_INVERT, 32'hf); repeat (3) @(posedge sys_clk);
    chk(pwm_out, 4'hf);
    wr(`DPWM_OFS_INVERT, 0); wr(`DPWM_OFS_ENABLE, 32'hf); wr(`DPWM_OFS_FAULT, 32'hf);
    fault_in <= 1; repeat (5) @(posedge sys_clk);
    chk(pwm_out, 4'h0);
    apb(0, `DPWM_OFS_RIS, 0); chk(rd[16], 1);
    fault_in <= 0; wr(`DPWM_OFS_ISC, 32'h10000); wr(`DPWM_OFS_FAULT, 0);
    apb(0, `DPWM_OFS_RIS, 0); chk(rd[16], 0);
  endtask
  initial begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; fault_in = 0; dbg_stall = 0;
    repeat (20) @(posedge sys_clk);
    srst <= 0;
    t_regs; t_down; t_gsync; t_updn; t_edge; t_trig; t_sync; t_stall; t_db; t_fault;
    finish_test;
  end
endmodule // dual_pwm_generator_deadband_bench
